//--- rtl/phyim_params.svh
// Constants of the PHY interrupt manager: register numbers, bit positions, timing.
// Assumes one includer per compile unit; guarded against double inclusion.
`ifndef PHYIM_PARAMS_SVH
`define PHYIM_PARAMS_SVH

// Register numbers on the serial management interface
`define PHYIM_REG_BASIC_STATUS    5'h01
`define PHYIM_REG_LP_ABILITY      5'h05
`define PHYIM_REG_AN_EXPANSION    5'h06
`define PHYIM_REG_MODE_CTRL       5'h11
`define PHYIM_REG_SOURCE_FLAGS    5'h1d
`define PHYIM_REG_ENABLE_MASK     5'h1e

// Status and control bit positions inside their registers
`define PHYIM_BIT_AN_COMPLETE     5
`define PHYIM_BIT_REMOTE_FAULT    4
`define PHYIM_BIT_LINK_STATUS     2
`define PHYIM_BIT_LP_ACK          14
`define PHYIM_BIT_PAR_DET_FAULT   4
`define PHYIM_BIT_PAGE_RECEIVED   1
`define PHYIM_BIT_ENERGY          1
`define PHYIM_BIT_ALT_SELECT      6

// Flag positions in the source-flag and mask registers
`define PHYIM_FLAG_LINK_UP        9
`define PHYIM_FLAG_WAKE           8
`define PHYIM_FLAG_ENERGY         7
`define PHYIM_FLAG_AN_DONE        6
`define PHYIM_FLAG_REMOTE_FAULT   5
`define PHYIM_FLAG_LINK_DOWN      4
`define PHYIM_FLAG_LP_ACK         3
`define PHYIM_FLAG_PAR_FAULT      2
`define PHYIM_FLAG_PAGE_RX        1

// Values
`define PHYIM_UNMAPPED_DATA       16'hFFFF
`define PHYIM_ZERO16              16'h0000
`define PHYIM_FLAGS_RESET         9'h000
`define PHYIM_READ_CLEAR_PAIR     9'h018
`define PHYIM_AN_CLEAR_PAIR       9'h003
`define PHYIM_LINK_DOWN_ONLY      9'h008

// Management frame
`define PHYIM_PREAMBLE_BITS       6'd32
`define PHYIM_ADDR_BITS           4'd10
`define PHYIM_TA_DATA_BITS        5'd18
`define PHYIM_OP_READ             2'b10
`define PHYIM_OP_WRITE            2'b01

// Timing of the late energy-present assertion
`define PHYIM_CLK_KHZ             50000
`define PHYIM_ENERGY_DELAY_MS     1000
`define PHYIM_ENERGY_PULSE_MS     256

`endif

//--- rtl/phyim_pkg.sv
// Types shared by the PHY interrupt manager and its management-frame slave.
// Assumes phyim_params.svh supplies all numeric constants.
package phyim_pkg;

  typedef logic [9:1] phyim_flags_t;

  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] data;
  } phyim_mreq_s;

  typedef enum logic [2:0] {
    MF_PREAMBLE,
    MF_START,
    MF_OPCODE,
    MF_ADDRESS,
    MF_PAYLOAD
  } phyim_frame_e;

  typedef enum logic [1:0] {
    LATE_IDLE,
    LATE_WAIT,
    LATE_PULSE
  } phyim_late_e;

endpackage

//--- rtl/phyim_mdio_slave.sv
// Serial management frame slave: decodes read and write frames on the data/clock pair.
// Assumes the clock is at least four times faster than the management clock.
`timescale 1ns/1ns
`include "phyim_params.svh"

module phyim_mdio_slave
  import phyim_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        mdc_i,
  input  wire logic        mdio_i,
  input  wire logic [4:0]  phy_addr_i,
  input  wire logic [15:0] rd_data_i,
  output logic             rd_pulse_o,
  output logic             wr_pulse_o,
  output phyim_mreq_s      req_o,
  output logic             mdio_o,
  output logic             mdio_oe_o
);

  logic [2:0]   mdc_sync_ff;
  logic [1:0]   dat_sync_ff;
  phyim_frame_e state_ff;
  logic [5:0]   cnt_ff;
  logic [1:0]   op_ff;
  logic [15:0]  shift_ff;
  logic [15:0]  out_ff;
  logic         rd_active_ff;
  logic [4:0]   out_step_ff;

  wire       mdc_rise = mdc_sync_ff[1] & ~mdc_sync_ff[2];
  wire       mdc_fall = ~mdc_sync_ff[1] & mdc_sync_ff[2];
  wire       bit_in   = dat_sync_ff[1];
  wire [9:0] addr_sh  = {shift_ff[8:0], bit_in};
  wire       addr_hit = (addr_sh[9:5] == phy_addr_i);
  wire       adr_last = (state_ff == MF_ADDRESS) && (cnt_ff[3:0] == `PHYIM_ADDR_BITS - 4'd1);
  wire       pay_last = (state_ff == MF_PAYLOAD) && (cnt_ff[4:0] == `PHYIM_TA_DATA_BITS - 5'd1);
  wire       rd_start = mdc_rise && adr_last && addr_hit && (op_ff == `PHYIM_OP_READ);

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      mdc_sync_ff <= 3'h0;
      dat_sync_ff <= 2'h0;
    end
    else
    begin
      mdc_sync_ff <= {mdc_sync_ff[1:0], mdc_i};
      dat_sync_ff <= {dat_sync_ff[0], mdio_i};
    end
  end

  // Frame decode on management clock rising edges
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_ff   <= MF_PREAMBLE;
      cnt_ff     <= 6'h00;
      op_ff      <= 2'h0;
      shift_ff   <= 16'h0000;
      req_o      <= '0;
      rd_pulse_o <= 1'b0;
      wr_pulse_o <= 1'b0;
    end
    else
    begin
      rd_pulse_o <= rd_start;
      wr_pulse_o <= 1'b0;
      if (mdc_rise)
      begin
        shift_ff <= {shift_ff[14:0], bit_in};
        cnt_ff   <= cnt_ff + 6'h01;
        unique case (state_ff)
          MF_PREAMBLE:
          begin
            if (bit_in)
              cnt_ff <= (cnt_ff == `PHYIM_PREAMBLE_BITS) ? cnt_ff : cnt_ff + 6'h01;
            else if (cnt_ff == `PHYIM_PREAMBLE_BITS)
              state_ff <= MF_START;
            else
              cnt_ff <= 6'h00;
          end
          MF_START:
          begin
            state_ff <= bit_in ? MF_OPCODE : MF_PREAMBLE;
            cnt_ff   <= 6'h00;
          end
          MF_OPCODE:
          begin
            op_ff <= {op_ff[0], bit_in};
            if (cnt_ff[0])
            begin
              state_ff <= MF_ADDRESS;
              cnt_ff   <= 6'h00;
            end
          end
          MF_ADDRESS:
          begin
            if (adr_last)
            begin
              req_o.addr <= addr_sh[4:0];
              cnt_ff     <= 6'h00;
              state_ff   <= (addr_hit && (op_ff == `PHYIM_OP_READ || op_ff == `PHYIM_OP_WRITE)) ?
                            MF_PAYLOAD : MF_PREAMBLE;
            end
          end
          MF_PAYLOAD:
          begin
            if (pay_last)
            begin
              state_ff <= MF_PREAMBLE;
              cnt_ff   <= 6'h00;
              if (op_ff == `PHYIM_OP_WRITE)
              begin
                req_o.data <= {shift_ff[14:0], bit_in};
                wr_pulse_o <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  // Read data is launched on falling edges: turnaround, driven zero, then 16 bits
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rd_active_ff <= 1'b0;
      out_step_ff  <= 5'h00;
      out_ff       <= 16'h0000;
      mdio_o       <= 1'b0;
      mdio_oe_o    <= 1'b0;
    end
    // Snapshot one edge after the address lands, so the register mux already decodes it
    else if (rd_pulse_o)
    begin
      rd_active_ff <= 1'b1;
      out_step_ff  <= 5'h00;
      out_ff       <= rd_data_i;
    end
    else if (rd_active_ff && mdc_fall)
    begin
      out_step_ff <= out_step_ff + 5'h01;
      if (out_step_ff == 5'h01)
      begin
        mdio_oe_o <= 1'b1;
        mdio_o    <= 1'b0;
      end
      else if (out_step_ff == `PHYIM_TA_DATA_BITS)
      begin
        mdio_oe_o    <= 1'b0;
        mdio_o       <= 1'b0;
        rd_active_ff <= 1'b0;
      end
      else if (out_step_ff != 5'h00)
      begin
        mdio_o <= out_ff[15];
        out_ff <= {out_ff[14:0], 1'b0};
      end
    end
  end

endmodule // phyim_mdio_slave

//--- rtl/phyim_top.sv
// PHY management and interrupt logic for one port: register access, flags, mask, combined interrupt.
// Assumes PHY status inputs come from logic on ref_clk_i; MDC/MDIO come from pins.
//
// Overview of operation
// R01: All PHY registers are reached over the two-wire serial management interface.
// R02: Reads of unimplemented register addresses return all ones.
// R03: Mask bit in register 30 sits at its flag's position in register 29, bits 9..1.
// R04: Reading register 29 reports the pending interrupt causes.
// R05: Flags with their mask bit set are ORed into one internal interrupt.
// R06: The combined interrupt is mirrored as this port's system status event bit.
// R07: Both release styles assert the interrupt identically; only release differs.
// R08: After reset the read-clear release style is active.
// R09: Writing one to the alternate select bit chooses write-one-recheck release.
// R10: Flags set on rising sources, and link-down on falling link status.
// R11: Read-clear: flag clears on source fall or register 29 read; link-down read only.
// R12: Read-clear: reading register 1 also clears remote-fault and link-down flags.
// R13: Read-clear: register 6 read, negotiation restart or link down clear bits 2 and 1.
// R14: Link-up source is the internal link state, not visible in any register.
// R15: Wake source is the OR of wake-control bits 7:4 ANDed with bits 3:0.
// R16: Energy flag released while energy high re-asserts the interrupt 256 ms about 1 s after loss.
// R17: Software should clear the energy mask bit when servicing that interrupt.
// R18: Energy bit starts at one, so its flag reads one after power-up.
// R19: Alternate style: software removes the cause, then writes one to the flag.
// R20: A written one re-checks the source; link-down releases when link status is high.
// R21: If the release condition holds, the flag and its contribution clear.
// R22: If the release condition fails, the flag stays set and the interrupt stays.
// R23: Flags latch regardless of mask; the mask gates only the interrupt.
`timescale 1ns/1ns
`include "phyim_params.svh"

module phyim_top
  import phyim_pkg::*;
#(
  parameter int unsigned ENERGY_DELAY_CYC = `PHYIM_ENERGY_DELAY_MS * `PHYIM_CLK_KHZ,
  parameter int unsigned ENERGY_PULSE_CYC = `PHYIM_ENERGY_PULSE_MS * `PHYIM_CLK_KHZ
)
(
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        mdc_i,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe_o,
  input  wire logic [4:0]  phy_addr_i,
  input  wire logic        internal_link_state_i,
  input  wire logic [7:0]  wake_control_status_i,
  input  wire logic        line_energy_present_i,
  input  wire logic        an_complete_i,
  input  wire logic        remote_fault_i,
  input  wire logic        link_status_i,
  input  wire logic        lp_acknowledge_i,
  input  wire logic        par_det_fault_i,
  input  wire logic        page_received_i,
  input  wire logic        an_restart_i,
  output logic             phy_irq_o,
  output logic             port_a_event_o
);

  function automatic logic addr_known(input logic [4:0] a);
    addr_known = (a == `PHYIM_REG_BASIC_STATUS) || (a == `PHYIM_REG_LP_ABILITY) ||
                 (a == `PHYIM_REG_AN_EXPANSION) || (a == `PHYIM_REG_MODE_CTRL) ||
                 (a == `PHYIM_REG_SOURCE_FLAGS) || (a == `PHYIM_REG_ENABLE_MASK);
  endfunction

  phyim_flags_t flags_ff;
  phyim_flags_t mask_ff;
  phyim_flags_t prev_ff;
  logic         alt_sel_ff;
  logic         armed_ff;
  phyim_late_e  late_ff;
  logic [31:0]  late_cnt_ff;
  logic         irq_ff;
  logic         event_ff;

  logic         rd_pulse;
  logic         wr_pulse;
  phyim_mreq_s  req;
  logic [15:0]  rd_data;

  // Serial management access to every register
  phyim_mdio_slave u_mdio // [R01]
  (
    .ref_clk_i  (ref_clk_i),
    .reset_i    (reset_i),
    .mdc_i      (mdc_i),
    .mdio_i     (mdio_i),
    .phy_addr_i (phy_addr_i),
    .rd_data_i  (rd_data),
    .rd_pulse_o (rd_pulse),
    .wr_pulse_o (wr_pulse),
    .req_o      (req),
    .mdio_o     (mdio_o),
    .mdio_oe_o  (mdio_oe_o)
  );

  wire rd_flags  = rd_pulse && (req.addr == `PHYIM_REG_SOURCE_FLAGS);
  wire rd_status = rd_pulse && (req.addr == `PHYIM_REG_BASIC_STATUS);
  wire rd_expan  = rd_pulse && (req.addr == `PHYIM_REG_AN_EXPANSION);
  wire wr_flags  = wr_pulse && (req.addr == `PHYIM_REG_SOURCE_FLAGS);
  wire wr_mask   = wr_pulse && (req.addr == `PHYIM_REG_ENABLE_MASK);
  wire wr_mode   = wr_pulse && (req.addr == `PHYIM_REG_MODE_CTRL);

  wire wake_event = |(wake_control_status_i[7:4] & wake_control_status_i[3:0]); // [R15]

  // Source vector; the link-down source is the inverted link status
  phyim_flags_t src;
  assign src = {internal_link_state_i, // [R14]
                wake_event,
                line_energy_present_i,
                an_complete_i,
                remote_fault_i,
                ~link_status_i,
                lp_acknowledge_i,
                par_det_fault_i,
                page_received_i};

  phyim_flags_t rise;
  phyim_flags_t fall;
  phyim_flags_t prim_clr;
  phyim_flags_t alt_clr;
  phyim_flags_t clr;
  phyim_flags_t nxt_flags;

  assign rise = src & ~prev_ff; // [R10]
  assign fall = ~src & prev_ff;

  // Read-clear release: source fall, register reads, negotiation events
  assign prim_clr = (fall & ~`PHYIM_LINK_DOWN_ONLY) // [R11]
                  | {9{rd_flags}} // [R11]
                  | (rd_status ? `PHYIM_READ_CLEAR_PAIR : `PHYIM_FLAGS_RESET) // [R12]
                  | ((rd_expan || an_restart_i || rise[`PHYIM_FLAG_LINK_DOWN]) ?
                     `PHYIM_AN_CLEAR_PAIR : `PHYIM_FLAGS_RESET); // [R13]

  // Write-one-recheck release: a written one clears only if its source is low
  assign alt_clr = wr_flags ? (req.data[9:1] & ~src) : `PHYIM_FLAGS_RESET; // [R20] [R21] [R22]

  assign clr       = alt_sel_ff ? alt_clr : prim_clr; // [R07]
  assign nxt_flags = rise | (flags_ff & ~clr); // [R23]

  // Mask as it stands after this edge, so a mask write reaches the interrupt with the flags
  phyim_flags_t nxt_mask;
  assign nxt_mask = wr_mask ? req.data[9:1] : mask_ff; // [R03]

  wire energy_released = clr[`PHYIM_FLAG_ENERGY] && flags_ff[`PHYIM_FLAG_ENERGY] &&
                         !rise[`PHYIM_FLAG_ENERGY] && src[`PHYIM_FLAG_ENERGY] &&
                         mask_ff[`PHYIM_FLAG_ENERGY];
  wire late_active = (late_ff == LATE_PULSE);
  wire nxt_irq     = (|(nxt_flags & nxt_mask)) || late_active; // [R05]

  // Register read mux
  assign rd_data = (req.addr == `PHYIM_REG_BASIC_STATUS) ?
                     (`PHYIM_ZERO16 | (16'(an_complete_i)  << `PHYIM_BIT_AN_COMPLETE)
                                    | (16'(remote_fault_i) << `PHYIM_BIT_REMOTE_FAULT)
                                    | (16'(link_status_i)  << `PHYIM_BIT_LINK_STATUS)) :
                   (req.addr == `PHYIM_REG_LP_ABILITY) ?
                     (16'(lp_acknowledge_i) << `PHYIM_BIT_LP_ACK) :
                   (req.addr == `PHYIM_REG_AN_EXPANSION) ?
                     ((16'(par_det_fault_i) << `PHYIM_BIT_PAR_DET_FAULT)
                     | (16'(page_received_i) << `PHYIM_BIT_PAGE_RECEIVED)) :
                   (req.addr == `PHYIM_REG_MODE_CTRL) ?
                     ((16'(alt_sel_ff) << `PHYIM_BIT_ALT_SELECT)
                     | (16'(line_energy_present_i) << `PHYIM_BIT_ENERGY)) :
                   (req.addr == `PHYIM_REG_SOURCE_FLAGS) ? {6'h00, flags_ff, 1'b0} : // [R04]
                   (req.addr == `PHYIM_REG_ENABLE_MASK)  ? {6'h00, mask_ff, 1'b0} : // [R03]
                   `PHYIM_UNMAPPED_DATA; // [R02]

  // Flags, edge history and configuration
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      flags_ff   <= `PHYIM_FLAGS_RESET;
      prev_ff    <= `PHYIM_FLAGS_RESET; // [R18]
      mask_ff    <= `PHYIM_FLAGS_RESET;
      alt_sel_ff <= 1'b0; // [R08]
    end
    else
    begin
      flags_ff <= nxt_flags;
      prev_ff  <= src;
      if (wr_mask)
        mask_ff <= req.data[9:1]; // [R03]
      if (wr_mode)
        alt_sel_ff <= req.data[`PHYIM_BIT_ALT_SELECT]; // [R09]
    end
  end

  // Late energy-present assertion after a release with energy still present
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      armed_ff    <= 1'b0;
      late_ff     <= LATE_IDLE;
      late_cnt_ff <= 32'h0000_0000;
    end
    else
    begin
      if (energy_released)
        armed_ff <= 1'b1;
      else if (!mask_ff[`PHYIM_FLAG_ENERGY] || (late_ff == LATE_WAIT))
        armed_ff <= 1'b0;
      unique case (late_ff)
        LATE_IDLE:
          if (armed_ff && fall[`PHYIM_FLAG_ENERGY])
          begin
            late_ff     <= LATE_WAIT; // [R16]
            late_cnt_ff <= ENERGY_DELAY_CYC - 32'd1;
          end
        LATE_WAIT:
          if (late_cnt_ff == 32'h0000_0000)
          begin
            late_ff     <= LATE_PULSE;
            late_cnt_ff <= ENERGY_PULSE_CYC - 32'd1;
          end
          else
            late_cnt_ff <= late_cnt_ff - 32'd1;
        LATE_PULSE:
          if (late_cnt_ff == 32'h0000_0000)
            late_ff <= LATE_IDLE;
          else
            late_cnt_ff <= late_cnt_ff - 32'd1;
        default:
          late_ff <= LATE_IDLE;
      endcase
    end
  end

  // Interrupt line and its system status mirror
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      irq_ff   <= 1'b0;
      event_ff <= 1'b0;
    end
    else
    begin
      irq_ff   <= nxt_irq; // [R05]
      event_ff <= nxt_irq; // [R06]
    end
  end

  assign phy_irq_o      = irq_ff;
  assign port_a_event_o = event_ff;

  a_unmapped_ones: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R02]
    (rd_pulse && !addr_known(req.addr)) |-> (rd_data == `PHYIM_UNMAPPED_DATA))
    else $error("unmapped read not all ones");

  a_flag_sets_edge: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R10]
    (|rise) |=> ((flags_ff & $past(rise)) == $past(rise)))
    else $error("flag not set on source edge");

  a_irq_from_mask: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R05]
    (|(flags_ff & mask_ff)) |-> irq_ff)
    else $error("enabled flag without interrupt");

  a_mask_gates_irq: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R23]
    (((nxt_flags & nxt_mask) == `PHYIM_FLAGS_RESET) && !late_active) |=> !irq_ff)
    else $error("interrupt without enabled flag");

  a_event_mirror: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R06]
    event_ff == phy_irq_o)
    else $error("status event differs from interrupt");

  a_reset_primary: assert property (@(posedge ref_clk_i) // [R08]
    $fell(reset_i) |-> !alt_sel_ff)
    else $error("alternate style active after reset");

  a_read_clears: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R11]
    (!alt_sel_ff && rd_flags) |=> (flags_ff == $past(rise)))
    else $error("register 29 read did not clear flags");

  a_status_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R12]
    (!alt_sel_ff && rd_status) |=> ((flags_ff[5:4] & ~$past(rise[5:4])) == 2'b00))
    else $error("register 1 read did not clear flags 5 and 4");

  a_alt_keep: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R22]
    (alt_sel_ff && wr_flags) |=> ((flags_ff & $past(flags_ff & src)) == $past(flags_ff & src)))
    else $error("flag released while source still active");

  a_alt_release: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R21]
    (alt_sel_ff && wr_flags) |=> ((flags_ff & $past(req.data[9:1] & ~src & ~rise)) == `PHYIM_FLAGS_RESET))
    else $error("flag kept although release condition held");

  a_alt_select: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R09]
    wr_mode |=> (alt_sel_ff == $past(req.data[`PHYIM_BIT_ALT_SELECT])))
    else $error("alternate select not taken");

  a_link_down_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R11]
    (!alt_sel_ff && flags_ff[`PHYIM_FLAG_LINK_DOWN] && !rd_flags && !rd_status) |=>
      flags_ff[`PHYIM_FLAG_LINK_DOWN])
    else $error("link-down flag lost without a register read");

  a_an_pair_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R13]
    (!alt_sel_ff && (rd_expan || an_restart_i)) |=>
      ((flags_ff[`PHYIM_FLAG_PAR_FAULT:`PHYIM_FLAG_PAGE_RX] &
        ~$past(rise[`PHYIM_FLAG_PAR_FAULT:`PHYIM_FLAG_PAGE_RX])) == 2'b00))
    else $error("negotiation flags not cleared");

  // Delay to the late energy pulse has run out
  sequence s_late_wait_done;
    (late_ff == LATE_WAIT) && (late_cnt_ff == 32'h0000_0000);
  endsequence

  a_late_pulse_irq: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R16]
    s_late_wait_done |=> (late_ff == LATE_PULSE) ##1 irq_ff)
    else $error("late energy pulse did not raise the interrupt");

endmodule // phyim_top

//--- dv/phyim_smc_model.sv
// Station management controller model: bit-bangs management read and write frames.
// Assumes a pull-up on the data wire, resolved by the bench; management clock stands low between frames.
`timescale 1ns/1ns

module phyim_smc_model
(
  input  wire logic ref_clk_i,
  input  wire logic mdio_i,
  output logic      mdc_o,
  output logic      mdio_o,
  output logic      mdio_oe_o
);
  initial
  begin
    mdc_o     = 1'b0;
    mdio_o    = 1'b1;
    mdio_oe_o = 1'b0;
  end

  // One frame, MSB first; the clock runs 4 ref cycles low then 4 high per bit
  task automatic xfer(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] q);
    logic [63:0] f;
    int          i;
    f = {32'hFFFF_FFFF, 2'b01, rd ? 2'b10 : 2'b01, pa, ra, 2'b10, wd};
    q = 16'h0000;
    for (i = 63; i >= 0; i--)
    begin
      mdc_o     <= 1'b0;
      mdio_o    <= f[i];
      mdio_oe_o <= !(rd && i < 18);
      repeat (4) @(posedge ref_clk_i);
      mdc_o <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      if (i < 16)
        q[i] = mdio_i;
      @(posedge ref_clk_i);
    end
    mdc_o     <= 1'b0;
    mdio_oe_o <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
  endtask
endmodule // phyim_smc_model

//--- dv/tb_phyim_top.sv
// Self-checking bench for the PHY interrupt manager.
// Assumes the station controller model drives all management traffic.
`timescale 1ns/1ns
`include "phyim_params.svh"

module tb_phyim_top;
  typedef struct packed {
    logic [9:1] s;
    logic [7:0] w;
    logic [9:1] m;
    logic [9:1] f;
    logic       q;
  } phyim_row_s;

  logic       clk, rst, an_rs, mdc, m_d, m_oe, d_o, d_oe, irq, pa;
  logic [9:1] src;
  logic [7:0] wcs;
  wire        mdio = d_oe ? d_o : (m_oe ? m_d : 1'b1);
  int         err_count, n_tests, d, w, k;
  phyim_row_s rows [11] = '{
    '{9'h100, 8'h00, 9'h1FF, 9'h100, 1'b1}, '{9'h000, 8'h11, 9'h1FF, 9'h080, 1'b1},
    '{9'h000, 8'h88, 9'h1FF, 9'h080, 1'b1}, '{9'h000, 8'h82, 9'h1FF, 9'h000, 1'b0},
    '{9'h040, 8'h00, 9'h1FF, 9'h040, 1'b1}, '{9'h020, 8'h00, 9'h1FF, 9'h020, 1'b1},
    '{9'h010, 8'h00, 9'h1FF, 9'h010, 1'b1}, '{9'h008, 8'h00, 9'h1FF, 9'h008, 1'b1},
    '{9'h004, 8'h00, 9'h1FF, 9'h004, 1'b1}, '{9'h002, 8'h00, 9'h1FF, 9'h002, 1'b1},
    '{9'h001, 8'h00, 9'h000, 9'h001, 1'b0}};

  phyim_top #(.ENERGY_DELAY_CYC(20), .ENERGY_PULSE_CYC(10)) i_phyim_top (
    .ref_clk_i(clk), .reset_i(rst), .mdc_i(mdc), .mdio_i(mdio), .mdio_o(d_o), .mdio_oe_o(d_oe),
    .phy_addr_i(5'h03), .internal_link_state_i(src[9]), .wake_control_status_i(wcs),
    .line_energy_present_i(src[7]), .an_complete_i(src[6]), .remote_fault_i(src[5]),
    .link_status_i(~src[4]), .lp_acknowledge_i(src[3]), .par_det_fault_i(src[2]),
    .page_received_i(src[1]), .an_restart_i(an_rs), .phy_irq_o(irq), .port_a_event_o(pa));

  phyim_smc_model i_phyim_smc_model (.ref_clk_i(clk), .mdio_i(mdio), .mdc_o(mdc), .mdio_o(m_d),
                                     .mdio_oe_o(m_oe));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd(input logic [4:0] ra, input logic [15:0] e);
    logic [15:0] q;
    i_phyim_smc_model.xfer(1'b1, 5'h03, ra, 16'h0000, q);
    chk($sformatf("reg_%h", ra), e, q);
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] v);
    logic [15:0] q;
    i_phyim_smc_model.xfer(1'b0, 5'h03, ra, v, q);
  endtask

  task automatic ck_irq(input logic e);
    chk("irq", {15'h0000, e}, {15'h0000, irq});
    chk("event", {15'h0000, e}, {15'h0000, pa});
  endtask

  task automatic set_src(input logic [9:1] v);
    @(posedge clk);
    src <= v;
    repeat (4) @(posedge clk);
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // Late energy pulse after the line goes quiet; returns when the pulse ends or the bound runs out
  task automatic late(output int dl, output int wd);
    set_src(9'h040);
    rd(`PHYIM_REG_SOURCE_FLAGS, 16'h0080);
    @(posedge clk);
    src <= 9'h000;
    for (dl = 0; dl < 60 && irq !== 1'b1; dl++) @(negedge clk);
    for (wd = 0; wd < 40 && irq === 1'b1; wd++) @(negedge clk);
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    err_count++;
    wrap_up();
  end

  initial
  begin
    err_count = 0;
    n_tests = 0;
    rst = 1'b1;
    an_rs = 1'b0;
    wcs = 8'h00;
    src = 9'h040;
    do_reset();
    rd(`PHYIM_REG_MODE_CTRL, 16'h0002);
    wr(`PHYIM_REG_SOURCE_FLAGS, 16'h0080);
    rd(`PHYIM_REG_SOURCE_FLAGS, 16'h0080);
    set_src(9'h000);
    set_src(9'h040);
    set_src(9'h000);
    rd(`PHYIM_REG_SOURCE_FLAGS, 16'h0000);
    rd(5'h1f, 16'hFFFF);
    wr(`PHYIM_REG_ENABLE_MASK, 16'hFFFF);
    rd(`PHYIM_REG_ENABLE_MASK, 16'h03FE);
    $display("test power_up done");
    for (k = 0; k < 11; k++)
    begin
      wr(`PHYIM_REG_ENABLE_MASK, {6'h00, rows[k].m, 1'b0});
      @(posedge clk);
      wcs <= rows[k].w;
      set_src(rows[k].s);
      ck_irq(rows[k].q);
      rd(`PHYIM_REG_SOURCE_FLAGS, {6'h00, rows[k].f, 1'b0});
      ck_irq(1'b0);
      rd(`PHYIM_REG_SOURCE_FLAGS, 16'h0000);
      @(posedge clk);
      wcs <= 8'h00;
      set_src(9'h000);
    end
    $display("test event_table done");
    wr(`PHYIM_REG_ENABLE_MASK, 16'h03FE);
    set_src(9'h018);
    rd(`PHYIM_REG_BASIC_STATUS, 16'h0010);
    rd(`PHYIM_REG_SOURCE_FLAGS, 16'h0000);
    set_src(9'h003);
    rd(`PHYIM_REG_AN_EXPANSION, 16'h0012);
    rd(`PHYIM_REG_SOURCE_FLAGS, 16'h0000);
    set_src(9'h000);
    set_src(9'h003);
    an_rs <= 1'b1;
    @(posedge clk);
    an_rs <= 1'b0;
    repeat (4) @(posedge clk);
    rd(`PHYIM_REG_SOURCE_FLAGS, 16'h0000);
    set_src(9'h000);
    set_src(9'h003);
    set_src(9'h00B);
    rd(`PHYIM_REG_SOURCE_FLAGS, 16'h0010);
    set_src(9'h000);
    $display("test extra_clears done");
    wr(`PHYIM_REG_MODE_CTRL, 16'h0040);
    rd(`PHYIM_REG_MODE_CTRL, 16'h0040);
    set_src(9'h020);
    ck_irq(1'b1);
    wr(`PHYIM_REG_SOURCE_FLAGS, 16'h0040);
    rd(`PHYIM_REG_SOURCE_FLAGS, 16'h0040);
    ck_irq(1'b1);
    set_src(9'h000);
    rd(`PHYIM_REG_SOURCE_FLAGS, 16'h0040);
    wr(`PHYIM_REG_SOURCE_FLAGS, 16'h0040);
    rd(`PHYIM_REG_SOURCE_FLAGS, 16'h0000);
    ck_irq(1'b0);
    set_src(9'h008);
    wr(`PHYIM_REG_SOURCE_FLAGS, 16'h0010);
    rd(`PHYIM_REG_SOURCE_FLAGS, 16'h0010);
    set_src(9'h000);
    wr(`PHYIM_REG_SOURCE_FLAGS, 16'h0010);
    rd(`PHYIM_REG_SOURCE_FLAGS, 16'h0000);
    $display("test alternate done");
    do_reset();
    wr(`PHYIM_REG_ENABLE_MASK, 16'h0080);
    late(d, w);
    chk("late_delay_ok", 16'h0001, {15'h0000, d >= 19 && d <= 25});
    chk("late_width", 16'h000A, 16'(w));
    set_src(9'h040);
    rd(`PHYIM_REG_SOURCE_FLAGS, 16'h0080);
    wr(`PHYIM_REG_ENABLE_MASK, 16'h0000);
    @(posedge clk);
    src <= 9'h000;
    for (d = 0; d < 60 && irq !== 1'b1; d++) @(negedge clk);
    chk("late_disarmed", 16'h003C, 16'(d));
    $display("test late_energy done");
    wrap_up();
  end
endmodule // tb_phyim_top
